/* File: rtl/mahb_map.svh */
`ifndef MAHB_MAP_SVH
`define MAHB_MAP_SVH
`define MAHB_OFF_SRC_LO   12'h000
`define MAHB_OFF_SRC_HI   12'h004
`define MAHB_OFF_HASH_LO  12'h008
`define MAHB_OFF_HASH_HI  12'h00C
`define MAHB_OFF_BOFF     12'h010
`define MAHB_RND_LSB      16
`define MAHB_COLL_LSB     12
`define MAHB_RND_SEED     10'h000
`define MAHB_BACKOFF_LIMIT 4'hA
`endif

/* File: rtl/mahb_pkg.sv */
`default_nettype none
package mahb_pkg;
    typedef logic [47:0] mahb_addr_t;
    typedef logic [5:0]  mahb_hash_t;
    typedef enum logic [1:0] {MAHB_IDLE, MAHB_BACKOFF} mahb_tx_e;
endpackage
`default_nettype wire

/* File: rtl/mahb_hash_if.sv */
`default_nettype none
interface mahb_hash_if;
    logic [47:0] dest_addr;
    logic [63:0] table_bits;
    logic        accept;
    modport filt (input dest_addr, input table_bits, output accept);
    modport user (output dest_addr, output table_bits, input accept);
endinterface
`default_nettype wire

/* File: rtl/mahb_hash_filter.sv */
`default_nettype none
module mahb_hash_filter (
    mahb_hash_if.filt hif
);
    import mahb_pkg::*;
    mahb_hash_t hash;
    // each hash bit folds every sixth address bit
    genvar i;
    generate
        for (i = 0; i < 6; i++) begin : g_fold
            assign hash[i] = ^{hif.dest_addr[i], hif.dest_addr[i+6], hif.dest_addr[i+12],
                               hif.dest_addr[i+18], hif.dest_addr[i+24], hif.dest_addr[i+30],
                               hif.dest_addr[i+36], hif.dest_addr[i+42]};
        end
    endgenerate
    assign hif.accept = hif.table_bits[hash];
endmodule
`default_nettype wire

/* File: rtl/mahb_regs.sv */
`include "mahb_map.svh"
`default_nettype none
module mahb_regs (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // apb slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    // receive filter
    input  wire logic         rx_da_valid,
    input  wire logic [47:0]  rx_da,
    output logic              rx_group_accept,
    // transmit events
    input  wire logic         tx_collision,
    input  wire logic         tx_slot_tick,
    input  wire logic         tx_frame_done,
    // station address and back-off status
    output logic      [47:0]  station_addr,
    output logic              tx_backoff_busy
);
    import mahb_pkg::*;

    // ************
    // registers
    // ************
    logic [15:0] src_lo_q, src_lo_d;
    logic [31:0] src_hi_q, src_hi_d;
    logic [31:0] hash_lo_q, hash_lo_d;
    logic [31:0] hash_hi_q, hash_hi_d;
    logic [31:0] rdata_d;
    logic        acc_q, acc_d;
    logic        wr, rd_hit;

    assign wr     = psel && penable && pwrite;
    assign pready = 1'b1;

    always_comb begin
        src_lo_d  = src_lo_q;
        src_hi_d  = src_hi_q;
        hash_lo_d = hash_lo_q;
        hash_hi_d = hash_hi_q;
        if (wr) begin
            unique case (paddr)
                `MAHB_OFF_SRC_LO:  src_lo_d  = pwdata[15:0];
                `MAHB_OFF_SRC_HI:  src_hi_d  = pwdata;
                `MAHB_OFF_HASH_LO: hash_lo_d = pwdata;
                `MAHB_OFF_HASH_HI: hash_hi_d = pwdata;
                default: ;
            endcase
        end
    end

    // ************
    // back-off state
    // ************
    logic [9:0] rnd_q, rnd_d;
    logic [3:0] coll_q, coll_d;
    logic [9:0] boff_q, boff_d;
    mahb_tx_e   st_q, st_d;
    logic [9:0] mask;
    logic [3:0] expo;

    always_comb begin
        rnd_d = {rnd_q[8:0], ~(rnd_q[9] ^ rnd_q[6])};
        coll_d = coll_q;
        boff_d = boff_q;
        st_d   = st_q;
        expo   = (coll_q + 4'h1 > `MAHB_BACKOFF_LIMIT) ? `MAHB_BACKOFF_LIMIT : coll_q + 4'h1;
        mask   = 10'(((11'h001 << expo) - 11'h001));
        unique case (st_q)
            MAHB_IDLE: ;
            MAHB_BACKOFF: begin
                if (tx_slot_tick && boff_q != 10'h000) begin
                    boff_d = boff_q - 10'h001;
                end
                if (boff_d == 10'h000) begin
                    st_d = MAHB_IDLE;
                end
            end
        endcase
        if (tx_collision) begin
            coll_d = coll_q + 4'h1;
            boff_d = rnd_q & mask;
            // a zero draw means no wait at all, so the next state is idle and busy is low
            st_d   = (boff_d != 10'h000) ? MAHB_BACKOFF : MAHB_IDLE;
        end else if (tx_frame_done) begin
            coll_d = 4'h0;
        end
    end

    // ************
    // read data
    // ************
    always_comb begin
        rdata_d = 32'h0000_0000;
        rd_hit  = 1'b1;
        unique case (paddr)
            `MAHB_OFF_SRC_LO:  rdata_d = {16'h0000, src_lo_q};
            `MAHB_OFF_SRC_HI:  rdata_d = src_hi_q;
            `MAHB_OFF_HASH_LO: rdata_d = hash_lo_q;
            `MAHB_OFF_HASH_HI: rdata_d = hash_hi_q;
            `MAHB_OFF_BOFF: begin
                rdata_d = {6'h00, rnd_q, coll_q, 2'b00, boff_q};
            end
            default: rd_hit = 1'b0;
        endcase
    end
    assign prdata  = rdata_d;
    assign pslverr = psel && penable && !rd_hit;

    // ************
    // hash filter
    // ************
    mahb_hash_if hif ();
    assign hif.dest_addr  = rx_da;
    assign hif.table_bits = {hash_hi_q, hash_lo_q};
    mahb_hash_filter u_filt (
        .hif (hif)
    );
    assign acc_d = rx_da_valid && rx_da[0] && hif.accept;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_lo_q  <= 16'h0000;
            src_hi_q  <= 32'h0000_0000;
            hash_lo_q <= 32'h0000_0000;
            hash_hi_q <= 32'h0000_0000;
            rnd_q     <= `MAHB_RND_SEED;
            coll_q    <= 4'h0;
            boff_q    <= 10'h000;
            st_q      <= MAHB_IDLE;
            acc_q     <= 1'b0;
        end else begin
            src_lo_q  <= src_lo_d;
            src_hi_q  <= src_hi_d;
            hash_lo_q <= hash_lo_d;
            hash_hi_q <= hash_hi_d;
            rnd_q     <= rnd_d;
            coll_q    <= coll_d;
            boff_q    <= boff_d;
            st_q      <= st_d;
            acc_q     <= acc_d;
        end
    end

    assign rx_group_accept = acc_q;
    assign station_addr    = {src_hi_q[7:0], src_hi_q[15:8], src_hi_q[23:16],
                              src_hi_q[31:24], src_lo_q[7:0], src_lo_q[15:8]};
    assign tx_backoff_busy = (st_q == MAHB_BACKOFF);
endmodule
`default_nettype wire

/* File: testbench/mahb_regs_props.sv */
`default_nettype none
module mahb_regs_props (
    input wire logic        pclk, presetn, psel, penable, pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic        pready, pslverr, rx_da_valid, rx_group_accept,
    input wire logic [47:0] rx_da, station_addr,
    input wire logic        tx_collision, tx_slot_tick, tx_frame_done, tx_backoff_busy
);
    timeunit 1ns; timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd, wr;
    assign rd = psel && penable && !pwrite;
    assign wr = psel && penable && pwrite;
    chk_lo_rsvd: assert property (rd && paddr == 12'h000 |-> prdata[31:16] == 16'h0000)
        else $error("low address upper half not zero");
    chk_lo_bytes: assert property (wr && paddr == 12'h000 |=>
        station_addr[15:0] == {$past(pwdata[7:0]), $past(pwdata[15:8])}) else $error("low bytes");
    chk_hi_bytes: assert property (wr && paddr == 12'h004 |=> station_addr[47:16] ==
        {$past(pwdata[7:0]), $past(pwdata[15:8]), $past(pwdata[23:16]), $past(pwdata[31:24])})
        else $error("high bytes");
    chk_boff_rsvd: assert property (rd && paddr == 12'h010 |->
        prdata[31:26] == 6'h00 && prdata[11:10] == 2'h0) else $error("back-off reserved bits");
    chk_acc_cause: assert property (rx_group_accept |-> $past(rx_da_valid && rx_da[0]))
        else $error("accept without group frame");
    chk_acc_unicast: assert property (rx_da_valid && !rx_da[0] |=> !rx_group_accept)
        else $error("individual frame accepted");
    chk_busy_hold: assert property (tx_backoff_busy && !tx_slot_tick && !tx_collision |=>
        tx_backoff_busy)
        else $error("back-off ended without slot");
    chk_unmapped_err: assert property (psel && penable && paddr > 12'h010 |-> pslverr)
        else $error("unmapped access not refused");
    cover property (rx_group_accept);
    cover property (tx_collision ##1 tx_backoff_busy);
    cover property (wr && paddr == 12'h004);
endmodule
bind mahb_regs mahb_regs_props u_props (.*);
`default_nettype wire

/* File: testbench/mahb_phy_model.sv */
`default_nettype none
module mahb_phy_model (
    input wire logic pclk,
    output logic     coll, tick, done
);
    timeunit 1ns; timeprecision 1ps;
    initial {coll, tick, done} = 3'b000;
    // one-cycle event pulse: {collision, slot, frame end}
    task automatic pulse(input logic [2:0] v);
        @(posedge pclk) {coll, tick, done} <= v;
        @(posedge pclk) {coll, tick, done} <= 3'b000;
    endtask
endmodule
`default_nettype wire

/* File: testbench/mac_addr_hash_backoff_regs_tb.sv */
`default_nettype none
module mac_addr_hash_backoff_regs_tb;
    timeunit 1ns; timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rxv = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, w, e;
    logic [47:0] rx_da = '0, sa, a;
    logic [5:0]  h;
    logic        pready, pslverr, acc, coll, tick, done, busy;
    logic [31:0] eq[$], mq[$];
    int          n_fail = 0, samples_checked = 0;
    initial forever #5 pclk = ~pclk;
    mahb_phy_model u_phy (.pclk(pclk), .coll(coll), .tick(tick), .done(done));
    mahb_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_da_valid(rxv), .rx_da(rx_da), .rx_group_accept(acc),
        .tx_collision(coll), .tx_slot_tick(tick), .tx_frame_done(done), .station_addr(sa),
        .tx_backoff_busy(busy));
    task automatic chk(input logic [47:0] s, input logic [47:0] x);
        samples_checked++;
        if (s !== x) begin
            n_fail++;
            $display("CHECK FAILED %0t got %h exp %h", $time, s, x);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // read notes expected value and mask
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d, x, m);
        @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, wr, ad, d};
        if (!wr) begin
            eq.push_back(x);
            mq.push_back(m);
        end
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (!pready);
        {psel, penable} <= 2'b00;
    endtask
    task automatic rx(input logic [47:0] v, input logic x);
        @(posedge pclk) {rxv, rx_da} <= {1'b1, v};
        @(posedge pclk) rxv <= 0;
        #1 chk(acc, x);
    endtask
    function automatic logic [5:0] fold(input logic [47:0] v);
        fold = '0;
        for (int k = 0; k < 8; k++) fold ^= v[6*k +: 6];
    endfunction
    always @(posedge pclk) if (psel && penable) begin
        chk(pready, 1'b1);
        chk(pslverr, paddr > 12'h010);
        if (pready && !pwrite) chk(prdata & mq.pop_front(), eq.pop_front());
    end
    initial begin
        w = $urandom(32'hA4DD0B02);
        repeat (2) @(posedge pclk);
        presetn <= 1;
        for (int i = 0; i < 4; i++) apb(0, 12'(4 * i), 0, 0, '1);
        apb(0, 12'h010, 0, 0, 32'hFC00_FFFF);
        w = $urandom;
        apb(1, 12'h000, w, 0, 0);
        apb(0, 12'h000, 0, {16'h0000, w[15:0]}, '1);
        apb(1, 12'h004, w, 0, 0);
        apb(0, 12'h004, 0, w, '1);
        chk(sa, {w[7:0], w[15:8], w[23:16], w[31:24], w[7:0], w[15:8]});
        repeat (8) begin
            a = {$urandom, $urandom} | 48'h1;
            h = fold(a);
            e = 32'h1 << h[4:0];
            apb(1, {8'h00, 1'b1, h[5], 2'b00}, e, 0, 0);
            apb(0, {8'h00, 1'b1, h[5], 2'b00}, 0, e, '1);
            rx(a, 1);
            rx(a & ~48'h1, 0);
            apb(1, {8'h00, 1'b1, h[5], 2'b00}, ~e, 0, 0);
            rx(a, 0);
        end
        apb(1, 12'h010, '1, 0, 0);
        apb(0, 12'h010, 0, 0, 32'hFC00_FC00);
        apb(0, 12'h020, 0, 0, '1);
        u_phy.pulse(3'b100);
        apb(0, 12'h010, 0, 32'h1000, 32'hF000);
        u_phy.pulse(3'b100);
        apb(0, 12'h010, 0, 32'h2000, 32'hF000);
        repeat (4) u_phy.pulse(3'b010);
        u_phy.pulse(3'b001);
        apb(0, 12'h010, 0, 0, 32'hF3FF);
        chk(busy, 0);
        complete_run;
    end
    initial begin
        #200000;
        n_fail++;
        complete_run;
    end
endmodule
`default_nettype wire
